// *** ctg_map.svh ***
// register map, field positions and reset values of the capture timer
// assumes an 8-bit register port addressed by word index
`ifndef CTG_MAP_SVH
`define CTG_MAP_SVH

// register port geometry
`define CTG_ADDR_W 3
`define CTG_DATA_W 8

// word offsets
`define CTG_OFS_MODE 3'h0
`define CTG_OFS_COUNT 3'h1
`define CTG_OFS_RISE 3'h2
`define CTG_OFS_FALL 3'h3
`define CTG_OFS_PIN_ONE 3'h4
`define CTG_OFS_PIN_THREE 3'h5
`define CTG_OFS_IRQ 3'h6

// timer_mode_reg fields
`define CTG_MODE_OVFH 7
`define CTG_MODE_OVFL 6
`define CTG_MODE_EDGE 5
`define CTG_MODE_CLR_HI 4
`define CTG_MODE_CLR_LO 3
`define CTG_MODE_OVIE 2
`define CTG_MODE_CKS_HI 1
`define CTG_MODE_CKS_LO 0

// single-bit registers
`define CTG_PIN_ONE_EN 0
`define CTG_PIN_THREE_NF 0
`define CTG_IRQ_FLAG 0

// reset values
`define CTG_RST_BYTE 8'h00
`define CTG_RST_CKS 2'h0
`define CTG_RST_CLR 2'h0

// clock divider taps
`define CTG_DIV_W 6
`define CTG_TAP_DIV64 5
`define CTG_TAP_DIV32 4
`define CTG_TAP_DIV2 0

`endif

// *** ctg_pkg.sv ***
// types shared by the capture timer modules
// assumes ctg_map.svh supplies the numeric constants
package ctg_pkg;
  // count clock sources selected by count_clock_select_hi/lo
  typedef enum logic [1:0] {
    CTG_CKS_DIV64 = 2'h0,
    CTG_CKS_DIV32 = 2'h1,
    CTG_CKS_DIV2 = 2'h2,
    CTG_CKS_WATCH4 = 2'h3
  } ctg_cks_t;
endpackage

// *** ctg_clk_div.sv ***
// count clock divider: system clock taps and watch clock divided by four
// assumes watch_clk_i is asynchronous and much slower than clk_sys_i
`timescale 1ns/1ps
`default_nettype none
`include "ctg_map.svh"
module ctg_clk_div
  import ctg_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // control
  input wire ctg_cks_t cks_i,
  input wire logic watch_clk_i,
  // selected clock level
  output logic sel_clk_o
);
  logic [`CTG_DIV_W-1:0] div_ff;
  logic wclk_meta_ff;
  logic wclk_sync_ff;
  logic wclk_prev_ff;
  logic [1:0] wdiv_ff;
  logic nxt_sel;

  // free-running prescaler of the system clock
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) div_ff <= '0;
    else div_ff <= div_ff + 1'b1;
  end

  // watch clock crosses in through two flops before edge detection
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wclk_meta_ff <= 1'b0;
      wclk_sync_ff <= 1'b0;
      wclk_prev_ff <= 1'b0;
    end else begin
      wclk_meta_ff <= watch_clk_i;
      wclk_sync_ff <= wclk_meta_ff;
      wclk_prev_ff <= wclk_sync_ff;
    end
  end

  // divide the synchronised watch clock by four; up to one system clock of jitter
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) wdiv_ff <= 2'h0;
    else if (wclk_sync_ff && !wclk_prev_ff) wdiv_ff <= wdiv_ff + 2'h1;
  end

  // source mux; a switch may show as an edge downstream, by design
  always_comb begin
    unique case (cks_i)
      CTG_CKS_DIV64: nxt_sel = div_ff[`CTG_TAP_DIV64];
      CTG_CKS_DIV32: nxt_sel = div_ff[`CTG_TAP_DIV32];
      CTG_CKS_DIV2: nxt_sel = div_ff[`CTG_TAP_DIV2];
      CTG_CKS_WATCH4: nxt_sel = wdiv_ff[1];
    endcase
  end

  // registered so that downstream edge detection sees a clean level
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) sel_clk_o <= 1'b0;
    else sel_clk_o <= nxt_sel;
  end
endmodule
`default_nettype wire

// *** ctg_noise_filter.sv ***
// digital low-pass filter: a chain of sample latches and a match detector
// assumes din_i is already synchronised to clk_sys_i
`timescale 1ns/1ps
`default_nettype none
module ctg_noise_filter #(
  parameter int TAPS = 5
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // sample strobe and data
  input wire logic sample_i,
  input wire logic din_i,
  // filtered level
  output logic dout_o
);
  logic [TAPS-1:0] taps_ff;
  logic all_hi;
  logic all_lo;

  if (TAPS < 2) begin : g_chk
    $error("ctg_noise_filter needs at least two taps");
  end

  // shift one sample per strobe
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) taps_ff <= '0;
    else if (sample_i) taps_ff <= {taps_ff[TAPS-2:0], din_i};
  end

  assign all_hi = &taps_ff;
  assign all_lo = ~|taps_ff;

  // output moves only when every latch agrees, else keeps its value
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) dout_o <= 1'b0;
    else if (all_hi) dout_o <= 1'b1;
    else if (all_lo) dout_o <= 1'b0;
  end

  a_filt_agree: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (dout_o != $past(dout_o)) |-> $past(all_hi || all_lo))
    else $error("filter output moved without full agreement");
endmodule
`default_nettype wire

// *** ctg_capture_timer.sv ***
// capture timer: 8-bit up counter with edge capture, noise filter and
// the spurious edges that come from switching clock, pin function or filter
// assumes a single-cycle register port and an asynchronous capture pin
`timescale 1ns/1ps
`default_nettype none
`include "ctg_map.svh"
// Function
// - count on falling edge of count clock
// - clock switch high to low counts once more
// - pin enable set, pin high: rising edge
// - pin enable cleared, pin high: falling edge
// - filter on high, early enable: rising edge
// - filter on low, early enable: falling edge
// - filter on high, late disable: falling edge
// - capture input low while pin disabled
// - pin rose, early filter on: rising edge
// - pin fell, early filter off: falling edge
// - spurious matching edge sets interrupt flag
// - filter updates only when five latches agree
// - no filter: sample on system clock
// - edges copy counter to capture registers
// - selected edge sets interrupt flag
module ctg_capture_timer
  import ctg_pkg::*;
#(
  parameter int CNT_W = 8,
  parameter int FILT_TAPS = 5
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // register port
  input wire logic [`CTG_ADDR_W-1:0] reg_addr_i,
  input wire logic [`CTG_DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [`CTG_DATA_W-1:0] reg_rdata_o,
  // pins
  input wire logic capture_pin_i,
  input wire logic watch_clk_i,
  // events and flag
  output logic capture_rise_o,
  output logic capture_fall_o,
  output logic timer_irq_flag_o
);
  localparam logic [CNT_W-1:0] CNT_MAX = '1;
  localparam logic [3:0] SETTLE = 4'(FILT_TAPS);

  if (CNT_W < 2 || CNT_W > `CTG_DATA_W || FILT_TAPS < 2 || FILT_TAPS > 15) begin : g_chk
    $error("ctg_capture_timer parameters out of range");
  end

  // register state
  logic ovfh_ff;
  logic ovfl_ff;
  logic irq_edge_sel_ff; // capture_irq_edge_select: 1 rising, 0 falling
  logic counter_clear_select_hi_ff;
  logic counter_clear_select_lo_ff;
  logic ovie_ff;
  ctg_cks_t cks_ff;
  logic capture_pin_enable_ff;
  logic noise_filter_enable_ff;
  logic timer_irq_flag_ff;
  logic [CNT_W-1:0] counter_ff;
  logic [CNT_W-1:0] rise_cap_ff;
  logic [CNT_W-1:0] fall_cap_ff;

  // datapath state
  logic pin_meta_ff;
  logic pin_sync_ff;
  logic sel_clk;
  logic sel_prev_ff;
  logic filt_out;
  logic [3:0] settle_ff;
  logic settled_ff;
  logic sig_prev_ff;
  logic pin_en_prev_ff;
  logic nf_prev_ff;

  // decoded strobes and combinational terms
  logic wr_mode;
  logic wr_pin_one;
  logic wr_pin_three;
  logic wr_irq;
  logic samp_stb;
  logic settled;
  logic src;
  logic sig;
  logic pin_en_rise;
  logic nf_rise;
  logic inj_fall;
  logic inj_rise;
  logic cap_rise;
  logic cap_fall;
  logic cnt_inc;
  logic cnt_clr;
  logic cnt_ovf;
  logic irq_set;
  logic [`CTG_DATA_W-1:0] nxt_rdata;

  assign wr_mode = reg_wr_i && (reg_addr_i == `CTG_OFS_MODE);
  assign wr_pin_one = reg_wr_i && (reg_addr_i == `CTG_OFS_PIN_ONE);
  assign wr_pin_three = reg_wr_i && (reg_addr_i == `CTG_OFS_PIN_THREE);
  assign wr_irq = reg_wr_i && (reg_addr_i == `CTG_OFS_IRQ);

  // capture pin through two flops before any logic sees it
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_meta_ff <= 1'b0;
      pin_sync_ff <= 1'b0;
    end else begin
      pin_meta_ff <= capture_pin_i;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  ctg_clk_div u_div (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .cks_i(cks_ff),
    .watch_clk_i(watch_clk_i),
    .sel_clk_o(sel_clk)
  );

  // filter samples on the count clock rising edge, else every system clock
  assign samp_stb = noise_filter_enable_ff ? (sel_clk && !sel_prev_ff) : 1'b1;

  ctg_noise_filter #(.TAPS(FILT_TAPS)) u_filt (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .sample_i(samp_stb),
    .din_i(pin_sync_ff),
    .dout_o(filt_out)
  );

  // samples taken since the filter was switched on, saturating
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) settle_ff <= 4'h0;
    else if (!noise_filter_enable_ff) settle_ff <= 4'h0;
    else if (samp_stb && settle_ff != SETTLE) settle_ff <= settle_ff + 4'h1;
  end
  // filter output lags the last sample by one clock; waiting for it avoids a false edge
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) settled_ff <= 1'b0;
    else settled_ff <= (settle_ff == SETTLE);
  end
  assign settled = settled_ff && (settle_ff == SETTLE);

  // raw pin is used until the filter has settled; noise passes in that window
  assign src = (noise_filter_enable_ff && settled) ? filt_out : pin_sync_ff;
  assign sig = capture_pin_enable_ff & src;

  // previous levels for edge and switch detection
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sig_prev_ff <= 1'b0;
      sel_prev_ff <= 1'b0;
      pin_en_prev_ff <= 1'b0;
      nf_prev_ff <= 1'b0;
    end else begin
      sig_prev_ff <= sig;
      sel_prev_ff <= sel_clk;
      pin_en_prev_ff <= capture_pin_enable_ff;
      nf_prev_ff <= noise_filter_enable_ff;
    end
  end

  assign pin_en_rise = capture_pin_enable_ff && !pin_en_prev_ff;
  assign nf_rise = noise_filter_enable_ff && !nf_prev_ff;

  // switching hazards that the plain level compare would not show
  assign inj_fall = pin_en_rise && noise_filter_enable_ff && !settled && !pin_sync_ff;
  assign inj_rise = nf_rise && capture_pin_enable_ff && pin_sync_ff && !filt_out;

  // gate changes and mux changes show as edges on their own
  always_comb begin
    cap_rise = sig && !sig_prev_ff;
    cap_fall = !sig && sig_prev_ff;
    if (inj_fall) begin
      cap_rise = 1'b0;
      cap_fall = 1'b1;
    end else if (inj_rise) begin
      cap_rise = 1'b1;
      cap_fall = 1'b0;
    end
  end

  // counter steps on the count clock falling edge, switches included
  assign cnt_inc = sel_prev_ff && !sel_clk;
  assign cnt_clr = (cap_rise && counter_clear_select_hi_ff) ||
                   (cap_fall && counter_clear_select_lo_ff);
  assign cnt_ovf = cnt_inc && !cnt_clr && (counter_ff == CNT_MAX);

  // clear wins over increment so a width reads from zero
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) counter_ff <= '0;
    else if (cnt_clr) counter_ff <= '0;
    else if (cnt_inc) counter_ff <= counter_ff + 1'b1;
  end

  // capture registers take the value before any clear
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rise_cap_ff <= '0;
      fall_cap_ff <= '0;
    end else begin
      if (cap_rise) rise_cap_ff <= counter_ff;
      if (cap_fall) fall_cap_ff <= counter_ff;
    end
  end

  // mode register; overflow flags set by hardware, cleared by writing 0
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ovfh_ff <= 1'b0;
      ovfl_ff <= 1'b0;
      irq_edge_sel_ff <= 1'b0;
      counter_clear_select_hi_ff <= 1'b0;
      counter_clear_select_lo_ff <= 1'b0;
      ovie_ff <= 1'b0;
      cks_ff <= CTG_CKS_DIV64;
    end else begin
      if (wr_mode) begin
        irq_edge_sel_ff <= reg_wdata_i[`CTG_MODE_EDGE];
        counter_clear_select_hi_ff <= reg_wdata_i[`CTG_MODE_CLR_HI];
        counter_clear_select_lo_ff <= reg_wdata_i[`CTG_MODE_CLR_LO];
        ovie_ff <= reg_wdata_i[`CTG_MODE_OVIE];
        cks_ff <= ctg_cks_t'({reg_wdata_i[`CTG_MODE_CKS_HI], reg_wdata_i[`CTG_MODE_CKS_LO]});
        if (!reg_wdata_i[`CTG_MODE_OVFH]) ovfh_ff <= 1'b0;
        if (!reg_wdata_i[`CTG_MODE_OVFL]) ovfl_ff <= 1'b0;
      end
      // set after clear so a coincident overflow is kept
      if (cnt_ovf && sig) ovfh_ff <= 1'b1;
      if (cnt_ovf && !sig) ovfl_ff <= 1'b1;
    end
  end

  // pin function and filter enables
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      capture_pin_enable_ff <= 1'b0;
      noise_filter_enable_ff <= 1'b0;
    end else begin
      if (wr_pin_one) capture_pin_enable_ff <= reg_wdata_i[`CTG_PIN_ONE_EN];
      if (wr_pin_three) noise_filter_enable_ff <= reg_wdata_i[`CTG_PIN_THREE_NF];
    end
  end

  // selected edge or enabled overflow raises the flag, spurious edges too
  assign irq_set = (cap_rise && irq_edge_sel_ff) || (cap_fall && !irq_edge_sel_ff) ||
                   (cnt_ovf && ovie_ff);

  // flag clears on a written 0; a set in the same cycle wins
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) timer_irq_flag_ff <= 1'b0;
    else if (irq_set) timer_irq_flag_ff <= 1'b1;
    else if (wr_irq && !reg_wdata_i[`CTG_IRQ_FLAG]) timer_irq_flag_ff <= 1'b0;
  end

  // read mux; unmapped words read as zero
  always_comb begin
    nxt_rdata = `CTG_RST_BYTE;
    unique case (reg_addr_i)
      `CTG_OFS_MODE: begin
        nxt_rdata[`CTG_MODE_OVFH] = ovfh_ff;
        nxt_rdata[`CTG_MODE_OVFL] = ovfl_ff;
        nxt_rdata[`CTG_MODE_EDGE] = irq_edge_sel_ff;
        nxt_rdata[`CTG_MODE_CLR_HI] = counter_clear_select_hi_ff;
        nxt_rdata[`CTG_MODE_CLR_LO] = counter_clear_select_lo_ff;
        nxt_rdata[`CTG_MODE_OVIE] = ovie_ff;
        nxt_rdata[`CTG_MODE_CKS_HI] = cks_ff[1];
        nxt_rdata[`CTG_MODE_CKS_LO] = cks_ff[0];
      end
      `CTG_OFS_COUNT: nxt_rdata[CNT_W-1:0] = counter_ff;
      `CTG_OFS_RISE: nxt_rdata[CNT_W-1:0] = rise_cap_ff;
      `CTG_OFS_FALL: nxt_rdata[CNT_W-1:0] = fall_cap_ff;
      `CTG_OFS_PIN_ONE: nxt_rdata[`CTG_PIN_ONE_EN] = capture_pin_enable_ff;
      `CTG_OFS_PIN_THREE: nxt_rdata[`CTG_PIN_THREE_NF] = noise_filter_enable_ff;
      `CTG_OFS_IRQ: nxt_rdata[`CTG_IRQ_FLAG] = timer_irq_flag_ff;
      default: nxt_rdata = `CTG_RST_BYTE;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) reg_rdata_o <= `CTG_RST_BYTE;
    else if (reg_rd_i) reg_rdata_o <= nxt_rdata;
    else reg_rdata_o <= `CTG_RST_BYTE;
  end

  // edge pulses registered for the outside, one cycle late
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      capture_rise_o <= 1'b0;
      capture_fall_o <= 1'b0;
    end else begin
      capture_rise_o <= cap_rise;
      capture_fall_o <= cap_fall;
    end
  end

  assign timer_irq_flag_o = timer_irq_flag_ff;

  a_count_on_fall: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (sel_prev_ff && !sel_clk && !cnt_clr) |=> counter_ff == $past(counter_ff) + 1'b1)
    else $error("counter missed a count clock falling edge");
  a_switch_extra: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    ($past(wr_mode, 2) && $past(sel_clk) && !sel_clk && !cnt_clr)
    |=> counter_ff != $past(counter_ff))
    else $error("high to low clock switch did not count");
  a_pin_en_rise: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (pin_en_rise && pin_sync_ff && !noise_filter_enable_ff) |=> rise_cap_ff == $past(counter_ff))
    else $error("pin enable with pin high gave no rising capture");
  a_pin_en_fall: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (!capture_pin_enable_ff && pin_en_prev_ff && sig_prev_ff) |-> cap_fall)
    else $error("pin disable with pin high gave no falling edge");
  a_filt_early_hi: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (pin_en_rise && noise_filter_enable_ff && !settled && pin_sync_ff) |-> cap_rise)
    else $error("early enable with pin high gave no rising edge");
  a_filt_early_lo: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (pin_en_rise && noise_filter_enable_ff && !settled && !pin_sync_ff)
    |=> fall_cap_ff == $past(counter_ff))
    else $error("early enable with pin low gave no falling capture");
  a_gate_low: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    !capture_pin_enable_ff |=> !sig_prev_ff)
    else $error("capture input not low while pin disabled");
  a_filt_on_rise: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (nf_rise && capture_pin_enable_ff && pin_sync_ff && !filt_out) |-> cap_rise)
    else $error("filter on after pin rise gave no rising edge");
  a_filt_off_fall: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (nf_prev_ff && !noise_filter_enable_ff && capture_pin_enable_ff && sig_prev_ff
     && !pin_sync_ff) |-> cap_fall)
    else $error("filter off after pin fall gave no falling edge");
  a_edge_sets_flag: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (cap_rise && irq_edge_sel_ff) ##1 1'b1 |-> timer_irq_flag_o)
    else $error("selected rising edge did not set the flag");
  a_clear_on_both: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    ((cap_rise || cap_fall) && counter_clear_select_hi_ff && counter_clear_select_lo_ff)
    |=> counter_ff == '0)
    else $error("both-edge clear did not zero the counter");
endmodule
`default_nettype wire

// *** ctg_pulse_src.sv ***
// partner model: drives the capture pin and makes watch clock pulses
// assumes requests are raised by nonblocking assignment on clk_sys_i edges
`timescale 1ns/1ps
`default_nettype none
module ctg_pulse_src (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // requests
  input wire logic pin_lvl_i,
  input wire logic [7:0] wpulse_i,
  input wire logic wgo_i,
  // pins and status
  output logic capture_pin_o,
  output logic watch_clk_o,
  output logic busy_o
);
  logic [7:0] left_ff;
  logic [4:0] ph_ff;
  // pin follows the request; widths are held to at least two clocks by the caller
  assign capture_pin_o = pin_lvl_i;
  // watch clock stands still low between bursts, so a stopped source is a known level
  assign busy_o = (left_ff != 8'h00);
  assign watch_clk_o = busy_o && (ph_ff < 5'h0A);
  // burst of pulses, twenty system clocks each
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      left_ff <= 8'h00;
      ph_ff <= 5'h00;
    end else if (!busy_o) begin
      if (wgo_i) left_ff <= wpulse_i;
      ph_ff <= 5'h00;
    end else if (ph_ff == 5'h13) begin
      left_ff <= left_ff - 8'h01;
      ph_ff <= 5'h00;
    end else begin
      ph_ff <= ph_ff + 5'h01;
    end
  end
endmodule
`default_nettype wire

// *** tb.sv ***
// testbench of the capture timer: register port, capture pin, watch clock
// assumes ctg_pulse_src as the far side; a stopped watch clock freezes the counter
`timescale 1ns/1ps
`default_nettype none
`include "ctg_map.svh"
module tb;
  logic clk_sys_i;
  logic resetn_i;
  logic [`CTG_ADDR_W-1:0] reg_addr_i;
  logic [`CTG_DATA_W-1:0] reg_wdata_i;
  logic reg_wr_i;
  logic reg_rd_i;
  logic [`CTG_DATA_W-1:0] reg_rdata_o;
  logic capture_pin_i;
  logic watch_clk_i;
  logic capture_rise_o;
  logic capture_fall_o;
  logic timer_irq_flag_o;
  logic pin_lvl;
  logic [7:0] wpulse;
  logic wgo;
  logic wbusy;
  logic es;
  logic clr;
  logic [7:0] a;
  logic [7:0] b;
  logic [7:0] v;
  logic [7:0] x;
  int nr;
  int nf;
  int r0;
  int f0;
  int fail_count;
  int samples_checked;

  ctg_capture_timer i_ctg_capture_timer (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .capture_pin_i(capture_pin_i), .watch_clk_i(watch_clk_i),
    .capture_rise_o(capture_rise_o), .capture_fall_o(capture_fall_o),
    .timer_irq_flag_o(timer_irq_flag_o)
  );
  ctg_pulse_src i_ctg_pulse_src (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .pin_lvl_i(pin_lvl), .wpulse_i(wpulse),
    .wgo_i(wgo), .capture_pin_o(capture_pin_i), .watch_clk_o(watch_clk_i), .busy_o(wbusy)
  );

  // 200 MHz system clock
  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end

  // edge pulses counted at the falling clock, away from the launching edge
  always @(negedge clk_sys_i) begin
    if (capture_rise_o === 1'b1) nr++;
    if (capture_fall_o === 1'b1) nf++;
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // flag expected after a cleared flag, given which edges occurred
  function automatic logic exp_flag(input int er, input int ef);
    return es ? (er > 0) : (ef > 0);
  endfunction

  task automatic conclude;
    if (fail_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [2:0] ad, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= ad;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [2:0] ad, output logic [7:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= ad;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1;
    d = reg_rdata_o;
  endtask

  // write followed by a settling wait, no checking
  task automatic qw(input logic [2:0] ad, input logic [7:0] d);
    wr(ad, d);
    repeat (8) @(posedge clk_sys_i);
  endtask

  // overflow interrupt kept off while pin modes change
  task automatic sm(input logic [1:0] ck);
    wr(`CTG_OFS_MODE, {2'b00, es, clr, clr, 1'b0, ck});
  endtask

  task automatic wp(input logic [7:0] n);
    @(posedge clk_sys_i);
    wpulse <= n;
    wgo <= 1'b1;
    @(posedge clk_sys_i);
    wgo <= 1'b0;
    #1;
    for (int i = 0; i < 400 && wbusy !== 1'b0; i++) begin
      @(posedge clk_sys_i);
      #1;
    end
    repeat (6) @(posedge clk_sys_i);
  endtask

  task automatic pulse(input int w);
    @(posedge clk_sys_i);
    pin_lvl <= 1'b1;
    repeat (w) @(posedge clk_sys_i);
    pin_lvl <= 1'b0;
    repeat (40) @(posedge clk_sys_i);
  endtask

  // one pin-function or filter register write with the pin set beside it, then edges, flag and captures
  task automatic ev(input logic [2:0] ad, input logic [7:0] d, input logic pv,
                    input int er, input int ef);
    logic [7:0] cb;
    logic [7:0] g;
    wr(`CTG_OFS_IRQ, 8'h00);
    rd(`CTG_OFS_COUNT, cb);
    r0 = nr;
    f0 = nf;
    @(posedge clk_sys_i);
    pin_lvl <= pv;
    wr(ad, d);
    repeat (8) @(posedge clk_sys_i);
    chk("rise count", er[7:0], 8'(nr - r0));
    chk("fall count", ef[7:0], 8'(nf - f0));
    chk("irq flag", {7'h00, exp_flag(er, ef)}, {7'h00, timer_irq_flag_o});
    if (er > 0) rd(`CTG_OFS_RISE, g);
    if (er > 0) chk("rise capture", cb, g);
    if (ef > 0) rd(`CTG_OFS_FALL, g);
    if (ef > 0) chk("fall capture", cb, g);
    rd(`CTG_OFS_COUNT, g);
    chk("counter", (clr && (er + ef > 0)) ? 8'h00 : cb, g);
  endtask

  // hang guard
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    fail_count++;
    conclude();
  end

  initial begin
    resetn_i = 1'b0;
    reg_addr_i = 3'h0;
    reg_wdata_i = 8'h00;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    pin_lvl = 1'b0;
    wpulse = 8'h00;
    wgo = 1'b0;
    es = 1'b1;
    clr = 1'b0;
    x = 8'h19;
    repeat (20) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd(3'(i), v);
      chk("reset value", 8'h00, v);
    end
    wr(3'h7, 8'hFF);
    wr(`CTG_OFS_RISE, 8'hFF);
    rd(3'h7, v);
    chk("unmapped read", 8'h00, v);
    rd(`CTG_OFS_RISE, v);
    chk("read-only capture", 8'h00, v);
    // count rate on the divided system clock: 320 clocks at sys/32
    sm(2'h1);
    rd(`CTG_OFS_COUNT, a);
    repeat (318) @(posedge clk_sys_i);
    rd(`CTG_OFS_COUNT, b);
    chk("div32 count", 8'h0A, b - a);
    // watch source: step until it falls, two more pulses leave it high
    sm(2'h3);
    repeat (4) @(posedge clk_sys_i);
    rd(`CTG_OFS_COUNT, a);
    b = a;
    for (int i = 0; i < 4; i++) begin
      if (b === a) wp(8'h01);
      if (b === a) rd(`CTG_OFS_COUNT, b);
    end
    wp(8'h02);
    rd(`CTG_OFS_COUNT, a);
    wp(8'h08);
    rd(`CTG_OFS_COUNT, b);
    chk("watch count", 8'h02, b - a);
    // two visits to sys/64 half a period apart: exactly one lands on a low level
    for (int i = 0; i < 2; i++) begin
      sm(2'h0);
      repeat (126) @(posedge clk_sys_i);
      sm(2'h3);
      repeat (30) @(posedge clk_sys_i);
    end
    rd(`CTG_OFS_COUNT, a);
    chk("switch count", 8'h05, a - b);
    // pin disabled: pin activity never reaches the capture logic
    r0 = nr;
    f0 = nf;
    pulse(6);
    chk("disabled edges", 8'h00, 8'(nr - r0 + nf - f0));
    pin_lvl <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      es = i[0];
      sm(2'h3);
      ev(`CTG_OFS_PIN_ONE, 8'h01, 1'b1, 1, 0);
      ev(`CTG_OFS_PIN_ONE, 8'h00, 1'b1, 0, 1);
    end
    clr = 1'b1;
    sm(2'h3);
    ev(`CTG_OFS_PIN_ONE, 8'h01, 1'b1, 1, 0);
    ev(`CTG_OFS_PIN_ONE, 8'h00, 1'b1, 0, 1);
    clr = 1'b0;
    sm(2'h3);
    // filter and pin enable switches with the pin high and low; filter changes with the pin disabled give no edge
    ev(`CTG_OFS_PIN_THREE, 8'h01, 1'b1, 0, 0);
    ev(`CTG_OFS_PIN_ONE, 8'h01, 1'b1, 1, 0);
    qw(`CTG_OFS_PIN_ONE, 8'h00);
    qw(`CTG_OFS_PIN_THREE, 8'h00);
    ev(`CTG_OFS_PIN_THREE, 8'h01, 1'b0, 0, 0);
    ev(`CTG_OFS_PIN_ONE, 8'h01, 1'b0, 0, 1);
    qw(`CTG_OFS_PIN_ONE, 8'h00);
    qw(`CTG_OFS_PIN_THREE, 8'h00);
    pin_lvl <= 1'b1;
    qw(`CTG_OFS_PIN_ONE, 8'h01);
    qw(`CTG_OFS_PIN_THREE, 8'h01);
    sm(2'h2);
    repeat (20) @(posedge clk_sys_i);
    sm(2'h3);
    ev(`CTG_OFS_PIN_ONE, 8'h00, 1'b1, 0, 1);
    qw(`CTG_OFS_PIN_THREE, 8'h00);
    ev(`CTG_OFS_PIN_ONE, 8'h01, 1'b0, 0, 0);
    ev(`CTG_OFS_PIN_THREE, 8'h01, 1'b1, 1, 0);
    sm(2'h2);
    repeat (20) @(posedge clk_sys_i);
    sm(2'h3);
    ev(`CTG_OFS_PIN_THREE, 8'h00, 1'b0, 0, 1);
    qw(`CTG_OFS_PIN_ONE, 8'h00);
    // settled filter on sys/2 sampling: short pulse removed, long one kept
    qw(`CTG_OFS_PIN_THREE, 8'h01);
    sm(2'h2);
    repeat (20) @(posedge clk_sys_i);
    qw(`CTG_OFS_PIN_ONE, 8'h01);
    r0 = nr;
    f0 = nf;
    pulse(4);
    chk("short filtered", 8'h00, 8'(nr - r0 + nf - f0));
    pulse(40);
    chk("long filtered", 8'h02, 8'(nr - r0 + nf - f0));
    qw(`CTG_OFS_PIN_ONE, 8'h00);
    qw(`CTG_OFS_PIN_THREE, 8'h00);
    sm(2'h3);
    qw(`CTG_OFS_PIN_ONE, 8'h01);
    r0 = nr;
    f0 = nf;
    pulse(3);
    chk("unfiltered short", 8'h02, 8'(nr - r0 + nf - f0));
    // random edge selects and widths against a frozen counter
    for (int i = 0; i < 12; i++) begin
      x = lfsr(x);
      es = x[0];
      sm(2'h3);
      wr(`CTG_OFS_IRQ, 8'h00);
      rd(`CTG_OFS_COUNT, a);
      r0 = nr;
      @(posedge clk_sys_i);
      pin_lvl <= 1'b1;
      repeat (6 + int'(x[3:1])) @(posedge clk_sys_i);
      chk("rise event", 8'h01, 8'(nr - r0));
      chk("flag on rise", {7'h00, es}, {7'h00, timer_irq_flag_o});
      rd(`CTG_OFS_RISE, v);
      chk("rise value", a, v);
      f0 = nf;
      @(posedge clk_sys_i);
      pin_lvl <= 1'b0;
      repeat (8) @(posedge clk_sys_i);
      chk("fall event", 8'h01, 8'(nf - f0));
      chk("flag on fall", 8'h01, {7'h00, timer_irq_flag_o});
      rd(`CTG_OFS_FALL, v);
      chk("fall value", a, v);
    end
    // overflow on sys/2 with the capture input low sets the low flag and the irq flag
    wr(`CTG_OFS_IRQ, 8'h00);
    wr(`CTG_OFS_MODE, 8'h06);
    repeat (520) @(posedge clk_sys_i);
    rd(`CTG_OFS_MODE, v);
    chk("overflow mode", 8'h46, v);
    chk("overflow flag", 8'h01, {7'h00, timer_irq_flag_o});
    conclude();
  end
endmodule
`default_nettype wire
